// file: src/cps_pkg.sv
package cps_pkg;
   // ----------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------
   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned T_BIAS_MS    = 220;
   localparam int unsigned T_DCD_MS     = 500;
   localparam int unsigned T_QUAL_MS    = 30;
   localparam int unsigned T_SS_STEP_US = 10;
   localparam int unsigned BIAS_CYC     = T_BIAS_MS * (CLK_HZ / 1000);
   localparam int unsigned DCD_CYC      = T_DCD_MS * (CLK_HZ / 1000);
   localparam int unsigned QUAL_CYC     = T_QUAL_MS * (CLK_HZ / 1000);
   localparam int unsigned SS_CYC       = T_SS_STEP_US * (CLK_HZ / 1_000_000);
   localparam int unsigned TMR_W        = 23;
   localparam int unsigned SS_W         = 7;

   // ----------------------------------------------------------
   // register map
   // ----------------------------------------------------------
   localparam int unsigned AW       = 12;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_ICL  = 12'h004;
   localparam logic [11:0] OFS_VIL  = 12'h008;
   localparam logic [11:0] OFS_STAT = 12'h00C;
   localparam logic [11:0] OFS_EFF  = 12'h010;

   localparam int unsigned B_HIZ  = 0;
   localparam int unsigned B_AUTO = 1;
   localparam int unsigned B_FRC  = 2;
   localparam int unsigned B_DCPB = 3;
   localparam int unsigned B_EXTL = 4;
   localparam int unsigned B_TRK  = 5;
   localparam int unsigned B_BPFM = 6;
   localparam int unsigned B_OPFM = 7;
   localparam int unsigned B_CHG  = 8;
   localparam int unsigned CTRL_W = 9;
   localparam logic [8:0]  CTRL_RST = 9'h102;

   localparam int unsigned B_FLAG = 3;
   localparam int unsigned B_OFLT = 4;
   localparam int unsigned B_OCP  = 5;
   localparam int unsigned B_ST   = 8;
   localparam int unsigned B_EVIL = 16;

   // ----------------------------------------------------------
   // limits: current 20 mA per code, voltage 40 mV per code
   // ----------------------------------------------------------
   localparam logic [7:0] ICL_MIN  = 8'h05;
   localparam logic [7:0] ICL_500  = 8'h19;
   localparam logic [7:0] ICL_1000 = 8'h32;
   localparam logic [7:0] ICL_1500 = 8'h4B;
   localparam logic [7:0] ICL_2100 = 8'h69;
   localparam logic [7:0] ICL_2400 = 8'h78;
   localparam logic [8:0] VIL_RST  = 9'h073;
   localparam logic [8:0] TRK_OFS  = 9'h00A;

   localparam logic [2:0] SRC_NONE = 3'h0;
   localparam logic [2:0] SRC_SDP  = 3'h1;
   localparam logic [2:0] SRC_CDP  = 3'h2;
   localparam logic [2:0] SRC_DCP  = 3'h3;
   localparam logic [2:0] SRC_UNK  = 3'h4;
   localparam logic [2:0] SRC_NSTD = 3'h5;

   localparam logic [1:0] BC_SDP = 2'h1;
   localparam logic [1:0] BC_CDP = 2'h2;

   // ----------------------------------------------------------
   // synchronised comparator inputs
   // ----------------------------------------------------------
   localparam int unsigned I_VBUS = 0;
   localparam int unsigned I_VBAT = 1;
   localparam int unsigned I_SLP  = 2;
   localparam int unsigned I_OVP  = 3;
   localparam int unsigned I_POOR = 4;
   localparam int unsigned I_SOVP = 5;
   localparam int unsigned I_HOT  = 6;
   localparam int unsigned I_P20  = 7;
   localparam int unsigned I_P28  = 8;
   localparam int unsigned I_M20  = 9;
   localparam int unsigned I_M28  = 10;
   localparam int unsigned I_OCP  = 11;
   localparam int unsigned I_LL   = 12;
   localparam int unsigned I_BST  = 13;
   localparam int unsigned I_BFLT = 14;
   localparam int unsigned I_BCV  = 15;
   localparam int unsigned I_BCT  = 16;
   localparam int unsigned NSYNC  = 18;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_BIAS = 5'h02,
      ST_QUAL = 5'h04,
      ST_DET  = 5'h08,
      ST_RUN  = 5'h10
   } cps_state_t;
endpackage

// file: src/cps_top.sv
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module cps_top
#(
   parameter int unsigned BIAS_CYC_P = cps_pkg::BIAS_CYC,
   parameter int unsigned DCD_CYC_P  = cps_pkg::DCD_CYC,
   parameter int unsigned QUAL_CYC_P = cps_pkg::QUAL_CYC
)(
   input  wire logic              pclk,          // bus clock
   input  wire logic              presetn,       // async reset
   input  wire logic [cps_pkg::AW-1:0] paddr,    // byte address
   input  wire logic              psel,          // select
   input  wire logic              penable,       // access phase
   input  wire logic              pwrite,        // write
   input  wire logic [31:0]       pwdata,        // write data
   output logic      [31:0]       prdata,        // read data
   output logic                   pready,        // ready
   output logic                   pslverr,       // unmapped
   input  wire logic              vbus_uvlo_ok,  // input above lockout
   input  wire logic              vbat_uvlo_ok,  // battery above depletion
   input  wire logic              vbus_sleep_ok, // input above battery+margin
   input  wire logic              vbus_ovp,      // input overvoltage
   input  wire logic              poor_src_ok,   // input holds under test load
   input  wire logic              sys_ovp,       // system overvoltage
   input  wire logic              die_hot,       // die above shutdown temp
   input  wire logic              dp_win_2p0,    // D+ in 2.0 V window
   input  wire logic              dp_win_2p8,    // D+ in 2.8 V window
   input  wire logic              dm_win_2p0,    // D- in 2.0 V window
   input  wire logic              dm_win_2p8,    // D- in 2.8 V window
   input  wire logic              lim_ocp,       // limit pin above 900 mV
   input  wire logic              light_load,    // light load seen
   input  wire logic              boost_active,  // boost mode running
   input  wire logic              boost_fault,   // boost fault event
   input  wire logic              bc_valid,      // port detector result valid
   input  wire logic [1:0]        bc_type,       // 1 std, 2 charging, 3 dedicated
   input  wire logic [7:0]        lim_code,      // limit pin setting code
   input  wire logic [8:0]        vbat_code,     // battery voltage code
   output logic                   bias_regulator_enable, // bias regulator on
   output logic                   poor_src_load_enable,  // test load on
   output logic                   detect_enable,         // data-line detection
   output logic                   converter_enable,      // converter switching
   output logic                   battery_switch_on,     // battery switch closed
   output logic                   dp_src_0p6_enable,     // D+ 0.6 V source
   output logic                   mid_rail_good,         // mid rail good pin
   output logic                   buck_pfm_enable,       // buck pfm mode
   output logic                   boost_pfm_enable,      // boost pfm mode
   output logic [7:0]             active_current_limit,  // applied limit
   output logic [8:0]             active_voltage_limit,  // applied limit
   output logic                   serial_enable,         // serial port enabled
   output logic                   por_irq_pulse          // interrupt pulse
);
   import cps_pkg::*;

   localparam logic [TMR_W-1:0] BIAS_LIM = TMR_W'(BIAS_CYC_P - 1);
   localparam logic [TMR_W-1:0] DCD_LIM  = TMR_W'(DCD_CYC_P - 1);
   localparam logic [TMR_W-1:0] QUAL_LIM = TMR_W'(QUAL_CYC_P - 1);
   localparam logic [SS_W-1:0]  SS_LIM   = SS_W'(SS_CYC - 1);

   // ----------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;

   assign raw_in = {bc_type, bc_valid, boost_fault, boost_active,
                    light_load, lim_ocp, dm_win_2p8, dm_win_2p0,
                    dp_win_2p8, dp_win_2p0, die_hot, sys_ovp,
                    poor_src_ok, vbus_ovp, vbus_sleep_ok,
                    vbat_uvlo_ok, vbus_uvlo_ok};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end

   wire s_vbus = sync_b[I_VBUS];
   wire s_vbat = sync_b[I_VBAT];
   wire s_slp  = sync_b[I_SLP];
   wire s_ovp  = sync_b[I_OVP];
   wire s_poor = sync_b[I_POOR];
   wire s_sovp = sync_b[I_SOVP];
   wire s_hot  = sync_b[I_HOT];
   wire s_ocp  = sync_b[I_OCP];
   wire s_ll   = sync_b[I_LL];
   wire s_bst  = sync_b[I_BST];
   wire s_bflt = sync_b[I_BFLT];
   wire s_bcv  = sync_b[I_BCV];
   wire [1:0] s_bct = sync_b[I_BCT+1:I_BCT];

   // ----------------------------------------------------------
   // power-on detection
   // ----------------------------------------------------------
   logic por_q;
   wire  por_ok   = s_vbus | s_vbat;
   wire  por_rise = por_ok & ~por_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_q         <= 1'b0;
         por_irq_pulse <= 1'b0;
         serial_enable <= 1'b0;
      end else begin
         por_q         <= por_ok;
         por_irq_pulse <= por_rise;
         serial_enable <= por_ok;
      end
   end

   // ----------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------
   logic [CTRL_W-1:0] ctrl;
   logic [7:0]        icl;
   logic [8:0]        vil;
   logic [2:0]        src_type;
   logic              src_flag;
   logic              ocp_flag;
   logic              boost_fault_status;
   logic              force_pend;
   logic [7:0]        eff_icl;
   logic [8:0]        eff_vil;
   cps_state_t        state;
   cps_state_t        next_state;

   wire sel_ctrl = (paddr == OFS_CTRL);
   wire sel_icl  = (paddr == OFS_ICL);
   wire sel_vil  = (paddr == OFS_VIL);
   wire sel_stat = (paddr == OFS_STAT);
   wire sel_eff  = (paddr == OFS_EFF);
   wire mapped   = sel_ctrl | sel_icl | sel_vil | sel_stat | sel_eff;
   wire acc      = psel & penable;
   wire wr       = acc & pwrite & mapped;
   wire rd_setup = psel & ~penable;

   wire hiz      = ctrl[B_HIZ];
   wire auto_det = ctrl[B_AUTO];
   wire dcp_bias = ctrl[B_DCPB];
   wire ext_lim  = ctrl[B_EXTL];
   wire trk_en   = ctrl[B_TRK];
   wire chg_en   = ctrl[B_CHG];

   wire [31:0] rd_ctrl = {{(32-CTRL_W){1'b0}}, ctrl};
   wire [31:0] rd_icl  = {24'h000000, icl};
   wire [31:0] rd_vil  = {23'h0, vil};
   wire [31:0] rd_stat = {19'h0, state, 2'h0, ocp_flag,
                          boost_fault_status, src_flag, src_type};
   wire [31:0] rd_eff  = {7'h0, eff_vil, 8'h00, eff_icl};
   wire [31:0] rd_mux  = sel_ctrl ? rd_ctrl :
                         sel_icl  ? rd_icl  :
                         sel_vil  ? rd_vil  :
                         sel_stat ? rd_stat :
                         sel_eff  ? rd_eff  : 32'h00000000;

   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end

   // ----------------------------------------------------------
   // power-up sequencer
   // ----------------------------------------------------------
   logic [TMR_W-1:0] tmr;

   wire bias_cond = s_vbus & s_slp & ~hiz;
   wire qual_ok   = ~s_ovp & s_poor;
   wire start_ok  = s_slp & ~s_ovp & ~hiz & ~s_sovp & ~s_hot;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (bias_cond) begin
               next_state = ST_BIAS;
            end
         end
         ST_BIAS: begin
            if (tmr == BIAS_LIM) begin
               next_state = ST_QUAL;
            end
         end
         ST_QUAL: begin
            if (!qual_ok) begin
               next_state = ST_BIAS;
            end else if (tmr == QUAL_LIM) begin
               next_state = auto_det ? ST_DET : ST_RUN;
            end
         end
         ST_DET: begin
            if (s_bcv || tmr == DCD_LIM) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (force_pend) begin
               next_state = ST_DET;
            end
         end
      endcase
      if (!bias_cond) begin
         next_state = ST_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         tmr   <= '0;
      end else begin
         state <= next_state;
         if (next_state != state) begin
            tmr <= '0;
         end else if (tmr != '1) begin
            tmr <= tmr + 1'b1;
         end
      end
   end

   wire qual_done = (state == ST_QUAL) & qual_ok & (tmr == QUAL_LIM) & bias_cond;
   wire det_end   = (state == ST_DET) & (next_state == ST_RUN);
   wire qualified = (state == ST_DET) | (state == ST_RUN);

   // ----------------------------------------------------------
   // detection result
   // ----------------------------------------------------------
   wire div1 = sync_b[I_P20] & sync_b[I_M28];
   wire div2 = sync_b[I_P28] & sync_b[I_M20];
   wire div3 = sync_b[I_P28] & sync_b[I_M28];

   wire [2:0] ns_type = (div1 | div2 | div3) ? SRC_NSTD : SRC_UNK;
   wire [7:0] ns_icl  = div1 ? ICL_1000 :
                        div2 ? ICL_2100 :
                        div3 ? ICL_2400 : ICL_500;
   wire [2:0] bc_src  = (s_bct == BC_SDP) ? SRC_SDP :
                        (s_bct == BC_CDP) ? SRC_CDP : SRC_DCP;
   wire [7:0] bc_icl  = (s_bct == BC_SDP) ? ICL_500 : ICL_1500;
   wire [2:0] det_src = s_bcv ? bc_src : ns_type;
   wire [7:0] det_icl = s_bcv ? bc_icl : ns_icl;

   // ----------------------------------------------------------
   // registers
   // ----------------------------------------------------------
   wire ocp_hit = ext_lim & s_ocp;
   wire frc_wr  = wr & sel_ctrl & pwdata[B_FRC];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl               <= CTRL_RST;
         icl                <= ICL_500;
         vil                <= VIL_RST;
         src_type           <= SRC_NONE;
         src_flag           <= 1'b0;
         ocp_flag           <= 1'b0;
         boost_fault_status <= 1'b0;
         force_pend         <= 1'b0;
      end else if (por_rise) begin
         ctrl               <= CTRL_RST;
         icl                <= ICL_500;
         vil                <= VIL_RST;
         src_type           <= SRC_NONE;
         src_flag           <= 1'b0;
         ocp_flag           <= 1'b0;
         boost_fault_status <= 1'b0;
         force_pend         <= 1'b0;
      end else begin
         if (wr && sel_ctrl) begin
            ctrl <= pwdata[CTRL_W-1:0] & ~(CTRL_W'(1) << B_FRC);
         end
         // detection wins a same-cycle host write
         if (det_end) begin
            icl <= det_icl;
         end else if (wr && sel_icl) begin
            icl <= pwdata[7:0];
         end
         if (wr && sel_vil) begin
            vil <= pwdata[8:0];
         end
         if (qual_done) begin
            src_type <= SRC_UNK;
         end else if (det_end) begin
            src_type <= det_src;
         end else if (!bias_cond) begin
            src_type <= SRC_NONE;
         end
         // a new event beats a write-one-to-clear in the same cycle
         if (qual_done) begin
            src_flag <= 1'b1;
         end else if (wr && sel_stat && pwdata[B_FLAG]) begin
            src_flag <= 1'b0;
         end
         if (ocp_hit) begin
            ocp_flag <= 1'b1;
         end else if (wr && sel_stat && pwdata[B_OCP]) begin
            ocp_flag <= 1'b0;
         end
         if (ocp_hit) begin
            boost_fault_status <= 1'b0;
         end else if (s_bflt) begin
            boost_fault_status <= 1'b1;
         end
         if (frc_wr) begin
            force_pend <= 1'b1;
         end else if (state == ST_DET) begin
            force_pend <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------
   // effective limits and soft start
   // ----------------------------------------------------------
   wire [8:0] trk_vil  = vbat_code + TRK_OFS;
   wire [7:0] next_icl = (ext_lim && lim_code < icl) ? lim_code : icl;
   wire [8:0] next_vil = (trk_en && trk_vil > vil) ? trk_vil : vil;

   logic [SS_W-1:0] ss_cnt;
   logic            conv_q;
   wire             conv_on = qualified & start_ok;
   wire             ss_tick = (ss_cnt == SS_LIM);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eff_icl              <= ICL_500;
         eff_vil              <= VIL_RST;
         active_current_limit <= ICL_MIN;
         active_voltage_limit <= VIL_RST;
         ss_cnt               <= '0;
         conv_q               <= 1'b0;
      end else begin
         eff_icl              <= next_icl;
         eff_vil              <= next_vil;
         active_voltage_limit <= next_vil;
         conv_q               <= conv_on;
         ss_cnt               <= (ss_tick || !conv_on) ? '0 : ss_cnt + 1'b1;
         if (!conv_on || !conv_q) begin
            active_current_limit <= ICL_MIN;
         end else if (active_current_limit > eff_icl) begin
            active_current_limit <= eff_icl;
         end else if (ss_tick && active_current_limit < eff_icl) begin
            active_current_limit <= active_current_limit + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------
   // power stage controls
   // ----------------------------------------------------------
   assign bias_regulator_enable = (state != ST_IDLE) & (state != ST_BIAS);
   assign poor_src_load_enable  = (state == ST_QUAL);
   assign detect_enable         = (state == ST_DET);
   assign converter_enable      = conv_on;
   assign battery_switch_on     = s_vbat & (~conv_on | chg_en);
   assign dp_src_0p6_enable     = (src_type == SRC_DCP) & dcp_bias & ~hiz;
   assign mid_rail_good         = ~hiz & (conv_on | ocp_hit);
   assign buck_pfm_enable       = conv_on & s_ll & ~ctrl[B_BPFM];
   assign boost_pfm_enable      = s_bst & s_ll & ~ctrl[B_OPFM];
endmodule
`default_nettype wire

// file: tb/cps_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cps_checker (
   input wire logic       pclk,                  // clock
   input wire logic       presetn,               // async reset
   input wire logic       vbus_uvlo_ok,          // input above lockout
   input wire logic       vbat_uvlo_ok,          // battery above depletion
   input wire logic       vbus_ovp,              // input overvoltage
   input wire logic       die_hot,               // die too hot
   input wire logic       light_load,            // light load
   input wire logic       bias_regulator_enable, // bias on
   input wire logic       poor_src_load_enable,  // test load on
   input wire logic       converter_enable,      // converter on
   input wire logic       battery_switch_on,     // battery switch
   input wire logic       buck_pfm_enable,       // buck pfm
   input wire logic       boost_pfm_enable,      // boost pfm
   input wire logic [7:0] active_current_limit,  // applied limit
   input wire logic       por_irq_pulse          // interrupt pulse
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_bias_needs_vbus: assert property (!vbus_uvlo_ok [*4] |-> !bias_regulator_enable)
      else $error("bias regulator on without input");
   chk_load_in_qual: assert property (poor_src_load_enable |-> bias_regulator_enable && !converter_enable)
      else $error("test load outside qualification");
   chk_conv_after_bias: assert property (converter_enable |-> bias_regulator_enable)
      else $error("converter on before bias regulator");
   chk_conv_ovp_off: assert property (vbus_ovp [*4] |-> !converter_enable)
      else $error("converter on during overvoltage");
   chk_conv_hot_off: assert property (die_hot [*4] |-> !converter_enable)
      else $error("converter on while die hot");
   chk_bsw_battery: assert property (!vbat_uvlo_ok [*4] |-> !battery_switch_on)
      else $error("battery switch closed without battery");
   chk_irq_one_cycle: assert property (por_irq_pulse |=> !por_irq_pulse)
      else $error("interrupt pulse longer than one cycle");
   chk_pfm_light: assert property (!light_load [*4] |-> !buck_pfm_enable && !boost_pfm_enable)
      else $error("pfm without light load");
   chk_ss_start: assert property ($rose(converter_enable) |-> ##[0:2] active_current_limit == 8'h05)
      else $error("soft start not from lowest code");
   chk_ss_step: assert property (converter_enable && $past(converter_enable)
      |-> active_current_limit <= $past(active_current_limit) + 8'h01)
      else $error("soft start skipped a code");
endmodule
bind cps_top cps_checker i_chk (.*);
`default_nettype wire

// file: tb/cps_port_model.sv
`timescale 1ns/100ps
`default_nettype none
module cps_port_model (
   input  wire logic       pclk,          // clock
   input  wire logic       detect_enable, // detection running
   input  wire logic [1:0] port_kind,     // 0 gives no answer
   output logic            bc_valid,      // result valid
   output logic [1:0]      bc_type        // result code
);
   logic [3:0] cnt = 4'h0;
   initial bc_valid = 1'h0;
   initial bc_type = 2'h0;
   // answers a few cycles into detection; the code toggles before that and while detection is off
   always @(posedge pclk) begin
      cnt <= detect_enable ? cnt + 4'h1 : 4'h0;
      bc_valid <= detect_enable && port_kind != 2'h0 && cnt > 4'h4;
      bc_type <= (detect_enable && cnt > 4'h4) ? port_kind : ~bc_type;
   end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import cps_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, bc_valid;
   logic vbus_uvlo_ok, vbat_uvlo_ok, vbus_sleep_ok, vbus_ovp, poor_src_ok, sys_ovp, die_hot;
   logic dp_win_2p0, dp_win_2p8, dm_win_2p0, dm_win_2p8, lim_ocp, light_load, boost_active, boost_fault;
   logic bias_regulator_enable, poor_src_load_enable, detect_enable, converter_enable, battery_switch_on;
   logic dp_src_0p6_enable, mid_rail_good, buck_pfm_enable, boost_pfm_enable, serial_enable, por_irq_pulse;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  bc_type, port_kind;
   logic [7:0]  lim_code, active_current_limit, icl;
   logic [8:0]  vbat_code, active_voltage_limit, v;
   logic [10:0] e;
   logic [1:0]  kinds [7] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
   logic [3:0]  wins [7] = '{4'h0, 4'h0, 4'h0, 4'h9, 4'h6, 4'h5, 4'h0};
   integer seed = 32'hB632, bad_count = 0, cmp_count = 0, irq_count = 0, i, k;
   cps_top #(.BIAS_CYC_P(20), .DCD_CYC_P(30), .QUAL_CYC_P(10)) i_dut (.*);
   cps_port_model i_port (.*);
   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) if (por_irq_pulse === 1'h1) irq_count <= irq_count + 1;
   function automatic logic [10:0] exp_det(input int n);
      case (n)
         0: return {SRC_SDP, ICL_500};
         1: return {SRC_CDP, ICL_1500};
         2: return {SRC_DCP, ICL_1500};
         3: return {SRC_NSTD, ICL_1000};
         4: return {SRC_NSTD, ICL_2100};
         5: return {SRC_NSTD, ICL_2400};
         default: return {SRC_UNK, ICL_500};
      endcase
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] act);
      cmp_count++;
      if (exp !== act) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, act);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic plug(input logic [1:0] kind, input logic [3:0] win);
      port_kind <= kind;
      {dp_win_2p0, dp_win_2p8, dm_win_2p0, dm_win_2p8} <= win;
      vbus_uvlo_ok <= 1'h0;
      repeat (5) @(posedge pclk);
      vbus_uvlo_ok <= 1'h1;
      for (i = 0; i < 300 && bias_regulator_enable !== 1'h1; i++) @(posedge pclk);
      check("bias wait", 1, i >= 20);
      for (i = 0; i < 300 && converter_enable !== 1'h1; i++) @(posedge pclk);
      for (i = 0; i < 100 && detect_enable === 1'h1; i++) @(posedge pclk);
      repeat (3) @(posedge pclk);
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      end_of_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, port_kind, lim_code, vbat_code} = '0;
      {vbus_uvlo_ok, vbat_uvlo_ok, vbus_sleep_ok, vbus_ovp, poor_src_ok, sys_ovp, die_hot} = '0;
      {dp_win_2p0, dp_win_2p8, dm_win_2p0, dm_win_2p8, lim_ocp, light_load, boost_active, boost_fault} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      vbat_uvlo_ok <= 1'h1;
      repeat (8) @(posedge pclk);
      check("irq pulses", 1, irq_count);
      check("serial", 1, serial_enable);
      check("battery switch", 1, battery_switch_on);
      check("bias", 0, bias_regulator_enable);
      apb(0, OFS_CTRL, 0); check("ctrl rst", 32'h102, rd);
      apb(0, OFS_VIL, 0); check("vil rst", 32'h073, rd);
      apb(0, 12'h0FC, 0); check("unmapped", 1, err);
      $display("test power on done");
      {vbus_sleep_ok, poor_src_ok} <= 2'h3;
      for (k = 0; k < 7; k++) begin
         icl = 8'h08 | (8'($random(seed)) & 8'h67);
         apb(1, OFS_ICL, icl); apb(0, OFS_ICL, 0); check("icl write", icl, rd);
         plug(kinds[k], wins[k]);
         e = exp_det(k);
         apb(0, OFS_STAT, 0); check("src type", e[10:8], rd[2:0]);
         apb(0, OFS_ICL, 0); check("icl detect", e[7:0], rd);
      end
      $display("test detection done");
      apb(1, OFS_CTRL, 32'h10A); plug(2'h3, 4'h0); check("dp src", 1, dp_src_0p6_enable);
      apb(1, OFS_CTRL, 32'h10B); repeat (5) @(posedge pclk);
      check("dp src hiz", 0, dp_src_0p6_enable);
      check("bias hiz", 0, {bias_regulator_enable, converter_enable});
      apb(1, OFS_CTRL, 32'h100); apb(1, OFS_STAT, 32'h8); apb(1, OFS_ICL, icl); plug(2'h1, 4'h0);
      apb(0, OFS_STAT, 0); check("qualified", 4'hC, rd[3:0]);
      apb(0, OFS_ICL, 0); check("icl kept", icl, rd);
      apb(1, OFS_CTRL, 32'h104); repeat (3) @(posedge pclk);
      for (i = 0; i < 100 && detect_enable === 1'h1; i++) @(posedge pclk);
      apb(0, OFS_ICL, 0); check("icl forced", ICL_500, rd);
      apb(1, OFS_CTRL, 32'h000); check("switch no charge", 0, battery_switch_on);
      apb(1, OFS_CTRL, 32'h100); check("switch charge", 1, battery_switch_on);
      {light_load, boost_active} <= 2'h3; repeat (5) @(posedge pclk);
      check("pfm", 2'h3, {buck_pfm_enable, boost_pfm_enable});
      apb(1, OFS_CTRL, 32'h140); check("pfm off", 0, buck_pfm_enable);
      light_load <= 1'h0;
      $display("test sequencing done");
      lim_code <= 8'h06 + (8'($random(seed)) & 8'h0F);
      apb(1, OFS_CTRL, 32'h100); apb(0, OFS_EFF, 0); check("eff pin off", ICL_500, rd[7:0]);
      apb(1, OFS_CTRL, 32'h110); apb(0, OFS_EFF, 0); check("eff pin on", lim_code, rd[7:0]);
      {lim_ocp, boost_fault} <= 2'h3; repeat (5) @(posedge pclk);
      apb(0, OFS_STAT, 0); check("ocp", 2'h2, rd[5:4]); check("mid rail", 1, mid_rail_good);
      lim_ocp <= 1'h0;
      v = 9'h060 | (9'($random(seed)) & 9'h07F);
      vbat_code <= 9'h050 | (9'($random(seed)) & 9'h07F);
      apb(1, OFS_VIL, v); apb(1, OFS_CTRL, 32'h120); apb(0, OFS_EFF, 0);
      check("vil track", {2{(v > vbat_code + TRK_OFS) ? v : vbat_code + TRK_OFS}},
         {rd[24:16], active_voltage_limit});
      $display("test limits done");
      apb(1, OFS_CTRL, 32'h100); apb(1, OFS_ICL, 32'h0E); plug(2'h1, 4'h0);
      check("ss start", ICL_MIN, active_current_limit);
      repeat (1100) @(posedge pclk);
      check("ss end", 8'h0E, active_current_limit);
      for (k = 0; k < 3; k++) begin
         {vbus_ovp, sys_ovp, die_hot} <= 3'h1 << k;
         repeat (6) @(posedge pclk);
         check("start block", 0, converter_enable);
         {vbus_ovp, sys_ovp, die_hot} <= 3'h0;
         repeat (6) @(posedge pclk);
      end
      $display("test start conditions done");
      end_of_test();
   end
endmodule
`default_nettype wire
